// [src/pwm_ctrl_pkg.sv]
// Constants, field layout and carrier types of the PWM channel upper control block
package pwm_ctrl_pkg;

   localparam int          NUM_CH            = 3;
   localparam int          ADDR_W            = 8;
   localparam int          CH_IDX_W          = 2;

   // Byte addresses of the per-channel control registers
   localparam logic [7:0]  CH0_CTRL_OFFSET   = 8'h2C;
   localparam logic [7:0]  CH1_CTRL_OFFSET   = 8'h3C;
   localparam logic [7:0]  CH2_CTRL_OFFSET   = 8'h4C;
   localparam logic [1:0]  CH_UNMAPPED       = 2'h3;

   // Field positions inside the control word
   localparam int          FLIP_BIT          = 26;
   localparam int          PRESCALE_MSB      = 25;
   localparam int          PRESCALE_LSB      = 22;
   localparam int          DB_EN_BIT         = 21;
   localparam int          DIVIDER_MSB       = 20;
   localparam int          DIVIDER_LSB       = 15;
   localparam int          SRC_SEL_BIT       = 14;
   localparam int          GATE_BIT          = 13;
   localparam int          PAIR_BIT          = 2;

   localparam logic [31:0] WORD_ZERO         = 32'h0000_0000;
   localparam logic [3:0]  PRESCALE_ZERO     = 4'h0;
   localparam logic [3:0]  PRESCALE_ONE      = 4'h1;
   localparam logic [7:0]  DB_CNT_ZERO       = 8'h00;
   localparam logic [7:0]  DB_CNT_ONE        = 8'h01;
   localparam logic [5:0]  IRQ_CNT_ZERO      = 6'h00;
   localparam logic [5:0]  IRQ_CNT_ONE       = 6'h01;

   typedef struct packed {
      logic       flip;
      logic [3:0] deadtime_prescale;
      logic       deadtime_enable;
      logic [5:0] interrupt_match_divider;
      logic       interrupt_source_select;
      logic       channel_interrupt_gate;
      logic       pair;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{flip: 1'b0, deadtime_prescale: 4'h0, deadtime_enable: 1'b0,
                                    interrupt_match_divider: 6'h00, interrupt_source_select: 1'b0,
                                    channel_interrupt_gate: 1'b0, pair: 1'b0};

   // Per-channel inputs from the counter and compare logic, same clock
   typedef struct packed {
      logic       pwm_raw;
      logic       compare_match;
      logic       period_match;
      logic [7:0] deadtime_compare_value;
   } chan_in_t;

   typedef enum logic [1:0] {
      DB_IDLE = 2'b01,
      DB_WAIT = 2'b10
   } db_state_t;

endpackage

// [src/pwm_ctrl_upper.sv]
// Upper control logic of three PWM channels with a classic Wishbone register slave
//
// Function
// - Swap bit exchanges primary and complement outputs; clear keeps them normal.
// - Four-bit prescale field divides the system clock into a dead-band tick.
// - Software writes load a reload register; working prescaler reloads on underflow.
// - Prescale field exists only when the build parameter is one.
// - Dead-band enable inserts delay on inactive-to-active transitions; clear inserts none.
// - Interrupt after divider+1 qualifying matches; zero means every match.
// - Source select one counts compare matches, zero counts period matches.
// - Per-channel gate bit allows interrupts; zero signals none.
// - Dead-band interval ends when the dead-band counter reaches the compare value.
// - Paired mode drives complement as inverse of primary, save dead-band time.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps

module pwm_ctrl_upper
   import pwm_ctrl_pkg::*;
#(
   parameter bit DEADTIME_PRESCALE_PRESENT = 1'b1
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rstn,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [ADDR_W-1:0]        wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   input  wire chan_in_t [NUM_CH-1:0]    chan_in,
   output logic      [NUM_CH-1:0]        pwm_out,
   output logic      [NUM_CH-1:0]        pwm_comp_out,
   output logic      [NUM_CH-1:0]        irq_out
);

   function automatic logic [1:0] ch_sel(input logic [ADDR_W-1:0] adr);
      logic [1:0] idx;
      case (adr)
         CH0_CTRL_OFFSET: idx = 2'h0;
         CH1_CTRL_OFFSET: idx = 2'h1;
         CH2_CTRL_OFFSET: idx = 2'h2;
         default:         idx = CH_UNMAPPED;
      endcase
      return idx;
   endfunction

   function automatic logic [31:0] ctrl_to_word(input ctrl_t c);
      logic [31:0] w;
      w = WORD_ZERO;
      w[FLIP_BIT] = c.flip;
      w[PRESCALE_MSB:PRESCALE_LSB] = c.deadtime_prescale;
      w[DB_EN_BIT] = c.deadtime_enable;
      w[DIVIDER_MSB:DIVIDER_LSB] = c.interrupt_match_divider;
      w[SRC_SEL_BIT] = c.interrupt_source_select;
      w[GATE_BIT] = c.channel_interrupt_gate;
      w[PAIR_BIT] = c.pair;
      return w;
   endfunction

   function automatic ctrl_t word_to_ctrl(input logic [31:0] w);
      ctrl_t c;
      c.flip = w[FLIP_BIT];
      // Without the prescaler the field is absent and stays zero
      c.deadtime_prescale = DEADTIME_PRESCALE_PRESENT ? w[PRESCALE_MSB:PRESCALE_LSB] : PRESCALE_ZERO;
      c.deadtime_enable = w[DB_EN_BIT];
      c.interrupt_match_divider = w[DIVIDER_MSB:DIVIDER_LSB];
      c.interrupt_source_select = w[SRC_SEL_BIT];
      c.channel_interrupt_gate = w[GATE_BIT];
      c.pair = w[PAIR_BIT];
      return c;
   endfunction

   function automatic logic [31:0] byte_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
      logic [31:0] w;
      w = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            w[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return w;
   endfunction

   // Bus slave state
   logic             ack_reg;
   logic             ack_next;
   logic [31:0]      rdata_reg;
   logic [31:0]      rdata_next;
   ctrl_t            ctrl_reg  [NUM_CH];
   ctrl_t            ctrl_next [NUM_CH];

   // Channel state
   logic [3:0]       scale_cnt_reg  [NUM_CH];
   logic [3:0]       scale_cnt_next [NUM_CH];
   db_state_t        db_state_reg   [NUM_CH];
   db_state_t        db_state_next  [NUM_CH];
   logic [7:0]       db_cnt_reg     [NUM_CH];
   logic [7:0]       db_cnt_next    [NUM_CH];
   logic [5:0]       irq_cnt_reg    [NUM_CH];
   logic [5:0]       irq_cnt_next   [NUM_CH];
   logic [NUM_CH-1:0] raw_d_reg;
   logic [NUM_CH-1:0] raw_d_next;
   logic [NUM_CH-1:0] pwm_reg;
   logic [NUM_CH-1:0] pwm_next;
   logic [NUM_CH-1:0] comp_reg;
   logic [NUM_CH-1:0] comp_next;
   logic [NUM_CH-1:0] irq_reg;
   logic [NUM_CH-1:0] irq_next;

   // Register slave: one wait state, ack for every address, unmapped reads zero
   always_comb begin
      logic [1:0] idx;
      logic       req;
      idx = ch_sel(wb_adr_i);
      req = wb_cyc_i && wb_stb_i && !ack_reg;
      ack_next = req;
      rdata_next = rdata_reg;
      for (int i = 0; i < NUM_CH; i++) begin
         ctrl_next[i] = ctrl_reg[i];
      end
      if (req) begin
         rdata_next = WORD_ZERO;
         for (int i = 0; i < NUM_CH; i++) begin
            if (idx == i[1:0]) begin
               // Prescale reads back the reload holding value
               rdata_next = ctrl_to_word(ctrl_reg[i]);
               if (wb_we_i) begin
                  // Only the reload register is written here
                  ctrl_next[i] = word_to_ctrl(byte_merge(ctrl_to_word(ctrl_reg[i]), wb_dat_i, wb_sel_i));
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ack_reg <= 1'b0;
         rdata_reg <= WORD_ZERO;
         for (int i = 0; i < NUM_CH; i++) begin
            ctrl_reg[i] <= CTRL_RESET;
         end
      end else begin
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         for (int i = 0; i < NUM_CH; i++) begin
            ctrl_reg[i] <= ctrl_next[i];
         end
      end
   end

   // Channel logic: prescaler, dead band, pairing, swap, decimation
   always_comb begin
      logic tick;
      logic raw;
      logic start;
      logic prim;
      logic comp;
      logic match;
      tick = 1'b0;
      raw = 1'b0;
      start = 1'b0;
      prim = 1'b0;
      comp = 1'b0;
      match = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         // Underflow reloads from the holding register, so a new value never cuts a period short
         if (!DEADTIME_PRESCALE_PRESENT) begin
            tick = 1'b1;
            scale_cnt_next[i] = PRESCALE_ZERO;
         end else if (scale_cnt_reg[i] == PRESCALE_ZERO) begin
            tick = 1'b1;
            scale_cnt_next[i] = ctrl_reg[i].deadtime_prescale;
         end else begin
            tick = 1'b0;
            scale_cnt_next[i] = scale_cnt_reg[i] - PRESCALE_ONE;
         end

         raw = chan_in[i].pwm_raw;
         raw_d_next[i] = raw;
         // Rising edge activates primary; falling edge activates complement when paired
         start = ctrl_reg[i].deadtime_enable &&
                 ((raw && !raw_d_reg[i]) || (ctrl_reg[i].pair && !raw && raw_d_reg[i]));
         db_state_next[i] = db_state_reg[i];
         db_cnt_next[i] = db_cnt_reg[i];
         case (db_state_reg[i])
            DB_IDLE: begin
               if (start) begin
                  db_state_next[i] = DB_WAIT;
                  db_cnt_next[i] = DB_CNT_ZERO;
               end
            end
            DB_WAIT: begin
               if (start) begin
                  db_cnt_next[i] = DB_CNT_ZERO;
               end else if (db_cnt_reg[i] == chan_in[i].deadtime_compare_value) begin
                  db_state_next[i] = DB_IDLE;
               end else if (tick) begin
                  db_cnt_next[i] = db_cnt_reg[i] + DB_CNT_ONE;
               end
            end
            default: begin
               db_state_next[i] = DB_IDLE;
               db_cnt_next[i] = DB_CNT_ZERO;
            end
         endcase

         // Both legs held inactive during the dead band
         prim = (db_state_next[i] == DB_IDLE) ? raw : 1'b0;
         comp = (ctrl_reg[i].pair && db_state_next[i] == DB_IDLE) ? !raw : 1'b0;
         pwm_next[i] = ctrl_reg[i].flip ? comp : prim;
         comp_next[i] = ctrl_reg[i].flip ? prim : comp;

         match = ctrl_reg[i].interrupt_source_select ? chan_in[i].compare_match
                                                     : chan_in[i].period_match;
         irq_next[i] = 1'b0;
         irq_cnt_next[i] = irq_cnt_reg[i];
         // Counting goes on while gated so re-enabling keeps the decimation phase
         if (match) begin
            if (irq_cnt_reg[i] == ctrl_reg[i].interrupt_match_divider) begin
               irq_cnt_next[i] = IRQ_CNT_ZERO;
               irq_next[i] = ctrl_reg[i].channel_interrupt_gate;
            end else begin
               irq_cnt_next[i] = irq_cnt_reg[i] + IRQ_CNT_ONE;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         raw_d_reg <= '0;
         pwm_reg <= '0;
         comp_reg <= '0;
         irq_reg <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            scale_cnt_reg[i] <= PRESCALE_ZERO;
            db_state_reg[i] <= DB_IDLE;
            db_cnt_reg[i] <= DB_CNT_ZERO;
            irq_cnt_reg[i] <= IRQ_CNT_ZERO;
         end
      end else begin
         raw_d_reg <= raw_d_next;
         pwm_reg <= pwm_next;
         comp_reg <= comp_next;
         irq_reg <= irq_next;
         for (int i = 0; i < NUM_CH; i++) begin
            scale_cnt_reg[i] <= scale_cnt_next[i];
            db_state_reg[i] <= db_state_next[i];
            db_cnt_reg[i] <= db_cnt_next[i];
            irq_cnt_reg[i] <= irq_cnt_next[i];
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign pwm_out = pwm_reg;
   assign pwm_comp_out = comp_reg;
   assign irq_out = irq_reg;

endmodule

// [verif/power_stage_model.sv]
// Power stage model that flags shoot-through on any output pair
`timescale 1ns/1ps
module power_stage_model
   import pwm_ctrl_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic [NUM_CH-1:0] high_side,
   input wire logic [NUM_CH-1:0] low_side,
   output int                    fault_cnt
);
   int cnt = 0;
   // One process owns the count, the port only mirrors it
   assign fault_cnt = cnt;
   // Sampled per clock; sub-cycle glitches not modelled
   always @(posedge sys_clk) begin
      if (|(high_side & low_side))
         cnt = cnt + 1;
   end
endmodule

// [verif/pwm_ctrl_upper_checker.sv]
// Port checker of the PWM upper control block, channel 0
`timescale 1ns/1ps
module pwm_ctrl_upper_checker
   import pwm_ctrl_pkg::*;
(
   input wire logic                  sys_clk,
   input wire logic                  rstn,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [ADDR_W-1:0]     wb_adr_i,
   input wire logic [3:0]            wb_sel_i,
   input wire logic [31:0]           wb_dat_i,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  wb_ack_o,
   input wire chan_in_t [NUM_CH-1:0] chan_in,
   input wire logic [NUM_CH-1:0]     pwm_out,
   input wire logic [NUM_CH-1:0]     pwm_comp_out,
   input wire logic [NUM_CH-1:0]     irq_out
);
   logic [31:0] c_reg;
   logic [5:0]  n_reg;
   logic        raw0, sm, hit, fl, pr, de, gt;
   assign raw0 = chan_in[0].pwm_raw;
   assign fl   = c_reg[FLIP_BIT];
   assign pr   = c_reg[PAIR_BIT];
   assign de   = c_reg[DB_EN_BIT];
   assign gt   = c_reg[GATE_BIT];
   assign sm   = c_reg[SRC_SEL_BIT] ? chan_in[0].compare_match : chan_in[0].period_match;
   assign hit  = sm && n_reg == c_reg[DIVIDER_MSB:DIVIDER_LSB];
   // Shadow of channel 0 control, byte lanes honoured
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         c_reg <= WORD_ZERO;
         n_reg <= IRQ_CNT_ZERO;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == CH0_CTRL_OFFSET && wb_sel_i[b])
               c_reg[8*b+:8] <= wb_dat_i[8*b+:8];
         end
         if (sm)
            n_reg <= hit ? IRQ_CNT_ZERO : n_reg + IRQ_CNT_ONE;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_no_overlap: assert property (!(|(pwm_out & pwm_comp_out)))
      else $error("both outputs active");
   a_idle_primary: assert property (!$past(de) && !$past(fl) |-> pwm_out[0] == $past(raw0))
      else $error("primary not raw");
   a_comp_paired: assert property (!$past(de) && !$past(fl) && $past(pr) |-> pwm_comp_out[0] == !$past(raw0))
      else $error("complement not inverse");
   a_flip_swap: assert property (!$past(de) && $past(fl) |-> pwm_comp_out[0] == $past(raw0))
      else $error("swap not applied");
   a_deadband_gap: assert property (de && $rose(raw0) |=> !pwm_out[0] && !pwm_comp_out[0])
      else $error("no dead band on rise");
   a_irq_decimate: assert property (irq_out[0] == ($past(hit) && $past(gt)))
      else $error("interrupt decimation wrong");
endmodule
bind pwm_ctrl_upper pwm_ctrl_upper_checker i_chk (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_in(chan_in), .pwm_out(pwm_out),
   .pwm_comp_out(pwm_comp_out), .irq_out(irq_out));

// [verif/pwm_ctrl_upper_tb.sv]
// Self-checking bench of the PWM upper control block
`timescale 1ns/1ps
module pwm_ctrl_upper_tb
   import pwm_ctrl_pkg::*;
;
   logic                  sys_clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pv, cv;
   logic [7:0]            adr = 8'h00;
   logic [3:0]            sel = 4'h0;
   logic [31:0]           wdat = 32'h0, rdat, rd, cw;
   chan_in_t [NUM_CH-1:0] chan_in = '0;
   logic [NUM_CH-1:0]     pwm_out, pwm_comp_out, irq_out;
   logic [3:0]            ps [3] = '{4'h0, 4'h0, 4'h3};
   logic [7:0]            dc [3] = '{8'h00, 8'h03, 8'h02};
   logic [5:0]            dv [4] = '{6'h00, 6'h02, 6'h02, 6'h02};
   logic                  sr [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
   logic                  gt [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   int                    ex [4] = '{6, 2, 2, 0};
   int                    errors = 0, comparisons = 0, irqs = 0, irqx = 0, faults, g, lo, hi, i0;
   always #2.5 sys_clk = ~sys_clk;
   pwm_ctrl_upper i_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .chan_in(chan_in),
      .pwm_out(pwm_out), .pwm_comp_out(pwm_comp_out), .irq_out(irq_out));
   power_stage_model i_stage (.sys_clk(sys_clk), .high_side(pwm_out), .low_side(pwm_comp_out), .fault_cnt(faults));
   always @(posedge sys_clk) irqs <= irqs + int'(irq_out[0]);
   always @(posedge sys_clk) irqx <= irqx + int'(|irq_out[NUM_CH-1:1]);
   task automatic tally_and_finish();
      $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         $display("[FAIL] %0t bus access not acknowledged", $time);
      end
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string what);
      bus(1'b0, a, 4'hF, WORD_ZERO);
      check32(rd, e, what);
   endtask
   task automatic pulse(input logic cmp);
      @(posedge sys_clk);
      chan_in[0].compare_match <= cmp;
      chan_in[0].period_match  <= !cmp;
      @(posedge sys_clk);
      chan_in[0].compare_match <= 1'b0;
      chan_in[0].period_match  <= 1'b0;
   endtask
   // Run takes under 2000 cycles; ten times that marks a hang
   initial begin
      #100000;
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      rdchk(CH0_CTRL_OFFSET, WORD_ZERO, "ctrl0 reset");
      bus(1'b1, CH1_CTRL_OFFSET, 4'hF, 32'hFFFF_FFFF);
      rdchk(CH1_CTRL_OFFSET, 32'h07FF_E004, "ctrl1 fields");
      bus(1'b1, CH2_CTRL_OFFSET, 4'h1, 32'hFFFF_FFFF);
      rdchk(CH2_CTRL_OFFSET, 32'h0000_0004, "ctrl2 lane");
      bus(1'b1, 8'h5C, 4'hF, 32'hFFFF_FFFF);
      rdchk(8'h5C, WORD_ZERO, "unmapped");
      rdchk(CH0_CTRL_OFFSET, WORD_ZERO, "ctrl0 alias");
      $display("Test registers done");
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, CH0_CTRL_OFFSET, 4'hF, {5'h00, m[1], 23'h000000, m[0], 2'h0});
         for (int r = 0; r < 2; r++) begin
            @(posedge sys_clk);
            chan_in[0].pwm_raw <= r[0];
            // Look mid-cycle, where the registered outputs have settled
            repeat (2) @(negedge sys_clk);
            pv = r[0];
            cv = m[0] & !r[0];
            check32({pwm_out[0], pwm_comp_out[0]}, m[1] ? {cv, pv} : {pv, cv}, "mode outputs");
         end
      end
      $display("Test output modes done");
      for (int k = 0; k < 3; k++) begin
         chan_in[0].deadtime_compare_value <= dc[k];
         bus(1'b1, CH0_CTRL_OFFSET, 4'hF, {6'h00, ps[k], 1'b1, 18'h00000, 1'b1, 2'h0});
         chan_in[0].pwm_raw <= 1'b0;
         repeat (100) @(posedge sys_clk);
         chan_in[0].pwm_raw <= 1'b1;
         g = 0;
         do begin
            @(negedge sys_clk);
            g++;
         end while (pwm_out[0] !== 1'b1 && g < 200);
         // First tick lands anywhere in the prescale period, hence a window
         lo = (int'(dc[k]) - 1) * (int'(ps[k]) + 1) + 2;
         hi = int'(dc[k]) * (int'(ps[k]) + 1) + 1;
         check32(32'(g - 2 >= lo && g - 2 <= hi), 32'h0000_0001, "dead band span");
      end
      $display("Test dead band done");
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, CH0_CTRL_OFFSET, 4'hF, {11'h000, dv[k], sr[k], gt[k], 13'h0000});
         i0 = irqs;
         repeat (6) begin
            pulse(sr[k]);
            pulse(!sr[k]);
         end
         repeat (3) @(posedge sys_clk);
         check32(irqs - i0, ex[k], "irq count");
      end
      $display("Test interrupts done");
      check32(faults, 0, "shoot-through");
      check32({pwm_out[2:1], pwm_comp_out[2:1]}, 32'h0000_0006, "idle channel outputs");
      check32(irqx, 0, "idle channel irq");
      tally_and_finish();
   end
endmodule
